//--- rtl/icsr_top.v
/*
  indirect register pointer, two data ports, two config bytes and the
  error flags of the main status/control register.
  assumes host i/o and config strobes are synchronous one-cycle pulses on
  ref_clk_i; collision and grant inputs are pins and get synchronised here, other event inputs are used as they arrive.
*/
`timescale 1ns/1ps
`include "icsr_defines.vh"

// Functional notes
// RQ1: config byte 46h always reads 00h.
// RQ2: config byte 47h returns the value loaded from the eeprom.
// RQ3: eeprom power byte also readable as low byte of bus config 37 to 44.
// RQ4: pointer holds an 8-bit index in bits 7 to 0.
// RQ5: pointer at 12h word or 14h dword; ctrl data port at 10h.
// RQ6: bus config data port at 16h word or 1Ch dword.
// RQ7: one pointer indexes both the ctrl and bus config spaces.
// RQ8: pointer bits 15 to 8 read zero; 31 to 16 undefined.
// RQ9: host must not write undefined indices; such reads return undefined.
// RQ10: pointer always accessible, cleared by resets, kept on stop.
// RQ11: status cause bits clear by writing one.
// RQ12: status bit 14 accepts writes, reads zero; 31 to 16 undefined.
// RQ13: bit 15 is read-only or of the three error flags.
// RQ14: half duplex, collision check fails if no collision in 20 bit times.
// RQ15: suppressed at serial full duplex; mii only at half-duplex 10base-t.
// RQ16: collision check flag never interrupts but sets error summary.
// RQ17: collision check flag cleared by write one, resets, or stop.
// RQ18: dropped frame sets flag and increments the dropped frame counter.
// RQ19: dropped frame interrupts if master enable and mask clear.
// RQ20: dropped frame flag cleared by write one, resets, or stop.
// RQ21: bus grant timeout flag sets after 153.6 us without grant.
// RQ22: a hardware set beats a same-cycle host clear.
module icsr_top #(
  parameter GRANT_TMO_CYC = `ICSR_GRANT_TMO_NS / `ICSR_CLK_NS,
  parameter CNT_W         = 16
) (
  input  wire        ref_clk_i,        // bus clock
  input  wire        rst_n_i,          // hardware reset, active low
  input  wire        sw_reset_i,       // software reset pulse
  input  wire        dword_io_mode_i,  // 1: dword i/o mode, 0: word
  input  wire        io_wr_i,          // i/o write strobe
  input  wire        io_rd_i,          // i/o read strobe
  input  wire [4:0]  io_addr_i,        // i/o byte offset
  input  wire [31:0] io_wdata_i,       // i/o write data
  output reg  [31:0] io_rdata_o,       // i/o read data
  input  wire        cfg_rd_i,         // config read strobe
  input  wire [7:0]  cfg_addr_i,       // config byte offset
  output reg  [7:0]  cfg_rdata_o,      // config read byte
  input  wire [7:0]  eeprom_pwr_i,     // power byte from eeprom loader
  input  wire        eeprom_load_i,    // eeprom byte valid pulse
  input  wire        half_duplex_i,    // mac in half duplex
  input  wire        mii_sel_i,        // 1: mii port, 0: serial port
  input  wire        phy_10bt_hd_i,    // phy is half-duplex 10base-t
  input  wire        bit_tick_i,       // one pulse per network bit time
  input  wire        tx_end_i,         // transmission ended pulse
  input  wire        col_i,            // collision input pin
  input  wire        rx_no_desc_i,     // frame lost, no descriptor pulse
  input  wire        bus_req_i,        // bus request level
  input  wire        bus_gnt_i,        // bus grant pin
  output reg         irq_output_n_o,   // interrupt, active low
  output reg  [7:0]  pointer_o,        // current register pointer
  output reg  [CNT_W-1:0] drop_cnt_o   // dropped frame counter
);

  reg [1:0]  col_s_q;
  reg [1:0]  gnt_s_q;
  reg [7:0]  pwr_q;
  reg        collision_check_fail_flag_q;
  reg        miss_q;
  reg        bus_grant_timeout_flag_q;
  reg        irq_master_enable_q;
  reg        stop_q;
  reg        dropped_frame_mask_q;
  reg        sqe_act_q;
  reg        sqe_seen_q;
  reg [4:0]  sqe_cnt_q;
  reg [31:0] gnt_cnt_q;

  // last tick index of the collision check window
  localparam [4:0] SQE_LAST = `ICSR_SQE_BIT_TIMES - 5'd1;

  wire       col_s  = col_s_q[1];
  wire       gnt_s  = gnt_s_q[1];
  wire       sreset = sw_reset_i;
  wire       ptr_hit = io_addr_i == (dword_io_mode_i ? `ICSR_IO_PTR_DWORD : `ICSR_IO_PTR_WORD);
  wire       cdp_hit = io_addr_i == `ICSR_IO_CDP_OFF;
  wire       bdp_hit = io_addr_i == (dword_io_mode_i ? `ICSR_IO_BDP_DWORD : `ICSR_IO_BDP_WORD);
  wire       st_wr   = io_wr_i && cdp_hit && pointer_o == `ICSR_IDX_STATUS;
  wire       mk_wr   = io_wr_i && cdp_hit && pointer_o == `ICSR_IDX_MASK;
  wire       stop_set = st_wr && io_wdata_i[`ICSR_BIT_STOP];
  wire       flag_clr = sreset || stop_set;
  wire       err_sum  = collision_check_fail_flag_q | miss_q | bus_grant_timeout_flag_q;
  wire       sqe_en   = half_duplex_i && (mii_sel_i ? phy_10bt_hd_i : 1'b1);
  // a collision seen up to and on the last tick makes the check pass
  wire       sqe_fail = sqe_act_q && bit_tick_i && !sqe_seen_q && !col_s
                        && sqe_cnt_q == SQE_LAST;
  wire       gnt_tmo  = bus_req_i && !gnt_s && gnt_cnt_q == GRANT_TMO_CYC - 1;

  // sticky flag update: set beats clear
  function flag_next;
    input cur;
    input set;
    input wr1;
    input hard_clr;
    begin
      if (set)
        flag_next = 1'b1; // [RQ22]
      else if (hard_clr || wr1)
        flag_next = 1'b0;
      else
        flag_next = cur;
    end
  endfunction

  // status word as read through the ctrl data port; unused bits read zero
  function [15:0] status_word;
    input dummy;
    begin
      status_word = 16'h0000;
      status_word[`ICSR_BIT_ERR]  = err_sum; // [RQ13] [RQ16]
      status_word[`ICSR_BIT_COLLISION_CHECK_FAIL_FLAG] = collision_check_fail_flag_q;
      status_word[`ICSR_BIT_MISS] = miss_q;
      status_word[`ICSR_BIT_BUS_GRANT_TIMEOUT_FLAG] = bus_grant_timeout_flag_q;
      status_word[`ICSR_BIT_IRQ_MASTER_ENABLE] = irq_master_enable_q;
      status_word[`ICSR_BIT_STOP] = stop_q; // [RQ12] bit 14 stays zero
    end
  endfunction

  // two-flop synchronisers for the collision and grant pins
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      col_s_q <= 2'b00;
      gnt_s_q <= 2'b00;
    end
    else
    begin
      col_s_q <= {col_s_q[0], col_i};
      gnt_s_q <= {gnt_s_q[0], bus_gnt_i};
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pwr_q <= 8'h00;
    else if (eeprom_load_i)
      pwr_q <= eeprom_pwr_i; // [RQ2]
  end

  // pointer: cleared by resets, stop does not touch it
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pointer_o <= 8'h00; // [RQ10]
    else if (sreset)
      pointer_o <= 8'h00; // [RQ10]
    else if (io_wr_i && ptr_hit)
      pointer_o <= io_wdata_i[7:0]; // [RQ4] [RQ5] [RQ8]
  end

  // collision self-test window after transmit end
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sqe_act_q  <= 1'b0;
      sqe_seen_q <= 1'b0;
      sqe_cnt_q  <= 5'd0;
    end
    else if (tx_end_i && sqe_en)
    begin
      sqe_act_q  <= 1'b1; // [RQ15]
      sqe_seen_q <= 1'b0;
      sqe_cnt_q  <= 5'd0;
    end
    else if (sqe_act_q)
    begin
      if (col_s)
        sqe_seen_q <= 1'b1;
      if (bit_tick_i)
      begin
        if (sqe_cnt_q == SQE_LAST)
          sqe_act_q <= 1'b0; // [RQ14]
        else
          sqe_cnt_q <= sqe_cnt_q + 5'd1;
      end
    end
  end

  // grant wait counter
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      gnt_cnt_q <= 32'd0;
    // restart after a timeout so a persisting stall sets the flag again
    else if (!bus_req_i || gnt_s || gnt_tmo)
      gnt_cnt_q <= 32'd0;
    else
      gnt_cnt_q <= gnt_cnt_q + 32'd1; // [RQ21]
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      collision_check_fail_flag_q  <= 1'b0;
      miss_q  <= 1'b0;
      bus_grant_timeout_flag_q  <= 1'b0;
      irq_master_enable_q  <= 1'b0;
      stop_q  <= 1'b1;
      dropped_frame_mask_q <= 1'b0;
    end
    else
    begin
      // stop and software reset clear the flags; a same-cycle event still sets
      collision_check_fail_flag_q <= flag_next(collision_check_fail_flag_q, sqe_fail, st_wr && io_wdata_i[`ICSR_BIT_COLLISION_CHECK_FAIL_FLAG],
                          flag_clr); // [RQ11] [RQ14] [RQ17]
      miss_q <= flag_next(miss_q, rx_no_desc_i, st_wr && io_wdata_i[`ICSR_BIT_MISS],
                          flag_clr); // [RQ11] [RQ18] [RQ20]
      bus_grant_timeout_flag_q <= flag_next(bus_grant_timeout_flag_q, gnt_tmo, st_wr && io_wdata_i[`ICSR_BIT_BUS_GRANT_TIMEOUT_FLAG],
                          flag_clr); // [RQ21]
      if (sreset)
      begin
        irq_master_enable_q <= 1'b0;
        stop_q <= 1'b1;
        dropped_frame_mask_q <= 1'b0;
      end
      else
      begin
        if (st_wr)
          irq_master_enable_q <= io_wdata_i[`ICSR_BIT_IRQ_MASTER_ENABLE] && !stop_set;
        if (stop_set)
          stop_q <= 1'b1;
        if (mk_wr)
          dropped_frame_mask_q <= io_wdata_i[`ICSR_BIT_MISS];
      end
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      drop_cnt_o <= {CNT_W{1'b0}};
    else if (sreset)
      drop_cnt_o <= {CNT_W{1'b0}};
    else if (rx_no_desc_i)
      // wraps silently at full scale
      drop_cnt_o <= drop_cnt_o + {{(CNT_W-1){1'b0}}, 1'b1}; // [RQ18]
  end

  // collision flag is never an interrupt source
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_output_n_o <= 1'b1;
    else
      irq_output_n_o <= !(irq_master_enable_q && miss_q && !dropped_frame_mask_q); // [RQ19] [RQ16]
  end

  // i/o read mux; unmapped indices read zero
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      io_rdata_o <= 32'h00000000;
    else if (io_rd_i)
    begin
      io_rdata_o <= 32'h00000000; // [RQ9]
      if (ptr_hit)
        io_rdata_o <= {`ICSR_UNDEF_HI, 8'h00, pointer_o}; // [RQ8]
      else if (cdp_hit)
      begin
        if (pointer_o == `ICSR_IDX_STATUS) // [RQ7]
          io_rdata_o <= {`ICSR_UNDEF_HI, status_word(1'b0)}; // [RQ12]
        else if (pointer_o == `ICSR_IDX_MASK)
          io_rdata_o <= {`ICSR_UNDEF_HI, 3'b000, dropped_frame_mask_q, 12'h000};
        else if (pointer_o == `ICSR_IDX_DROPCNT)
          io_rdata_o <= {{(32-CNT_W){1'b0}}, drop_cnt_o};
      end
      else if (bdp_hit && pointer_o >= `ICSR_IDX_PWR_FIRST
               && pointer_o <= `ICSR_IDX_PWR_LAST) // [RQ6] [RQ7]
        io_rdata_o <= {24'h000000, pwr_q}; // [RQ3]
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cfg_rdata_o <= 8'h00;
    else if (cfg_rd_i)
    begin
      // other config offsets belong to other blocks and read zero here
      if (cfg_addr_i == `ICSR_CFG_BSE_OFF)
        cfg_rdata_o <= `ICSR_BSE_VALUE; // [RQ1]
      else if (cfg_addr_i == `ICSR_CFG_PWR_OFF)
        cfg_rdata_o <= pwr_q; // [RQ2]
      else
        cfg_rdata_o <= 8'h00;
    end
  end

endmodule

//--- rtl/icsr_defines.vh
/*
  constants for the indirect register access and status block.
  assumes inclusion by bare name from rtl/.
*/
`ifndef ICSR_DEFINES_VH
`define ICSR_DEFINES_VH
`define ICSR_CFG_BSE_OFF     8'h46
`define ICSR_CFG_PWR_OFF     8'h47
`define ICSR_BSE_VALUE       8'h00
`define ICSR_IO_CDP_OFF      5'h10
`define ICSR_IO_PTR_WORD     5'h12
`define ICSR_IO_PTR_DWORD    5'h14
`define ICSR_IO_BDP_WORD     5'h16
`define ICSR_IO_BDP_DWORD    5'h1C
`define ICSR_IDX_STATUS      8'h00
`define ICSR_IDX_MASK        8'h03
`define ICSR_IDX_DROPCNT     8'h70
`define ICSR_IDX_PWR_FIRST   8'h25
`define ICSR_IDX_PWR_LAST    8'h2C
`define ICSR_BIT_ERR         15
`define ICSR_BIT_RES14       14
`define ICSR_BIT_COLLISION_CHECK_FAIL_FLAG        13
`define ICSR_BIT_MISS        12
`define ICSR_BIT_BUS_GRANT_TIMEOUT_FLAG        11
`define ICSR_BIT_IRQ_MASTER_ENABLE        6
`define ICSR_BIT_STOP        2
`define ICSR_SQE_BIT_TIMES   5'd20
`define ICSR_GRANT_TMO_NS    153600
`define ICSR_CLK_NS          40
`define ICSR_UNDEF_HI        16'h0000
`endif

//--- dv/icsr_host_model.sv
/*
  host model: issues i/o writes, i/o reads and config reads.
  assumes ref_clk_i runs; signals change at the falling edge only.
*/
`timescale 1ns/1ps
module icsr_host_model (
  input  wire        ref_clk_i,  // bus clock
  output reg         io_wr_o,    // i/o write strobe
  output reg         io_rd_o,    // i/o read strobe
  output reg  [4:0]  io_addr_o,  // i/o offset
  output reg  [31:0] io_wdata_o, // write data
  output reg         cfg_rd_o,   // config read strobe
  output reg  [7:0]  cfg_addr_o  // config offset
);
  initial {io_wr_o, io_rd_o, io_addr_o, io_wdata_o, cfg_rd_o, cfg_addr_o} = 0;
  // k: 0 write, 1 read, 2 config read; only defined indices are written
  task cyc(input [1:0] k, input [7:0] a, input [31:0] d);
  begin
    @(negedge ref_clk_i);
    {io_wr_o, io_rd_o, cfg_rd_o} = {k == 2'h0, k == 2'h1, k == 2'h2};
    io_addr_o = a[4:0];
    cfg_addr_o = a;
    io_wdata_o = d;
    @(negedge ref_clk_i);
    {io_wr_o, io_rd_o, cfg_rd_o} = 3'h0;
    io_wdata_o = ~d;
    @(negedge ref_clk_i);
  end
  endtask
endmodule

//--- dv/icsr_top_assertions.sv
/*
  port checker for icsr_top.
  assumes one clock domain, ref_clk_i, reset rst_n_i.
*/
`timescale 1ns/1ps
module icsr_chk #(
  parameter CNT_W = 16
) (
  input wire             ref_clk_i,       // clock
  input wire             rst_n_i,         // reset
  input wire             sw_reset_i,      // sw reset
  input wire             dword_io_mode_i, // dword mode
  input wire             io_wr_i,         // write
  input wire             io_rd_i,         // read
  input wire [4:0]       io_addr_i,       // offset
  input wire [31:0]      io_wdata_i,      // wdata
  input wire [31:0]      io_rdata_o,      // rdata
  input wire             cfg_rd_i,        // cfg read
  input wire [7:0]       cfg_addr_i,      // cfg offset
  input wire [7:0]       cfg_rdata_o,     // cfg data
  input wire             rx_no_desc_i,    // frame lost
  input wire             irq_output_n_o,  // irq
  input wire [7:0]       pointer_o,       // pointer
  input wire [CNT_W-1:0] drop_cnt_o       // counter
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire [4:0] pa = dword_io_mode_i ? 5'h14 : 5'h12;
  wire       pw = io_wr_i && io_addr_i == pa;
  wire [7:0] wl = io_wdata_i[7:0];
  ptr_load_a: assert property (pw && !sw_reset_i |=> pointer_o == $past(wl))
    else $error("pointer load wrong");
  ptr_keep_a: assert property (!pw && !sw_reset_i |=> $stable(pointer_o))
    else $error("pointer changed");
  ptr_clear_a: assert property (sw_reset_i |=> pointer_o == 8'h00)
    else $error("pointer not cleared");
  bse_zero_a: assert property (cfg_rd_i && cfg_addr_i == 8'h46 |-> ##[1:2] cfg_rdata_o == 8'h00)
    else $error("bridge byte nonzero");
  ptr_rsvd_a: assert property (io_rd_i && io_addr_i == pa |-> ##[1:2] io_rdata_o[15:8] == 8'h00)
    else $error("pointer high byte nonzero");
  cnt_step_a: assert property (rx_no_desc_i && !sw_reset_i |=> drop_cnt_o == $past(drop_cnt_o) + 1'b1)
    else $error("counter did not step");
  cnt_keep_a: assert property (!rx_no_desc_i && !sw_reset_i |=> $stable(drop_cnt_o))
    else $error("counter moved");
  irq_quiet_a: assert property (sw_reset_i |-> ##2 irq_output_n_o)
    else $error("irq after sw reset");
  rdata_hold_a: assert property (!io_rd_i && !$past(io_rd_i) |=> $stable(io_rdata_o))
    else $error("read data moved");
endmodule

bind icsr_top icsr_chk #(.CNT_W(CNT_W)) u_chk (.ref_clk_i, .rst_n_i, .sw_reset_i,
  .dword_io_mode_i, .io_wr_i, .io_rd_i, .io_addr_i, .io_wdata_i, .io_rdata_o, .cfg_rd_i,
  .cfg_addr_i, .cfg_rdata_o, .rx_no_desc_i, .irq_output_n_o, .pointer_o, .drop_cnt_o);

//--- dv/test_indirect_csr_access_and_status.sv
/*
  testbench: register tests through host i/o and config cycles.
  assumes icsr_top and the host model; grant timeout set to 16 cycles.
*/
`timescale 1ns/1ps
module test_indirect_csr_access_and_status;
  reg ref_clk_i = 0, rst_n_i = 0, sw_reset_i = 0, dword_io_mode_i = 0, eeprom_load_i = 0;
  reg half_duplex_i = 0, mii_sel_i = 0, phy_10bt_hd_i = 0, bit_tick_i = 0, tx_end_i = 0;
  reg col_i = 0, rx_no_desc_i = 0, bus_req_i = 0, bus_gnt_i = 0;
  reg  [7:0]  eeprom_pwr_i = 8'h00;
  wire        io_wr_i, io_rd_i, cfg_rd_i, irq_output_n_o;
  wire [4:0]  io_addr_i;
  wire [31:0] io_wdata_i, io_rdata_o;
  wire [7:0]  cfg_addr_i, cfg_rdata_o, pointer_o;
  wire [15:0] drop_cnt_o;
  integer     err_total = 0, total_checks = 0, i;
  always #20 ref_clk_i = ~ref_clk_i;
  icsr_host_model u_host (.ref_clk_i, .io_wr_o(io_wr_i), .io_rd_o(io_rd_i),
    .io_addr_o(io_addr_i), .io_wdata_o(io_wdata_i), .cfg_rd_o(cfg_rd_i), .cfg_addr_o(cfg_addr_i));
  icsr_top #(.GRANT_TMO_CYC(16), .CNT_W(16)) DUT (.ref_clk_i, .rst_n_i, .sw_reset_i,
    .dword_io_mode_i, .io_wr_i, .io_rd_i, .io_addr_i, .io_wdata_i, .io_rdata_o, .cfg_rd_i,
    .cfg_addr_i, .cfg_rdata_o, .eeprom_pwr_i, .eeprom_load_i, .half_duplex_i, .mii_sel_i,
    .phy_10bt_hd_i, .bit_tick_i, .tx_end_i, .col_i, .rx_no_desc_i, .bus_req_i, .bus_gnt_i,
    .irq_output_n_o, .pointer_o, .drop_cnt_o);
  task nclk;
    @(negedge ref_clk_i);
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input [63:0] nm);
  begin
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("mismatch %0s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task wr(input [4:0] a, input [31:0] d);
    u_host.cyc(2'h0, {3'h0, a}, d);
  endtask
  task rd(input [4:0] a, input [31:0] m, input [31:0] exp);
  begin
    u_host.cyc(2'h1, {3'h0, a}, 32'h0);
    chk(io_rdata_o & m, exp, "io_rdata");
  end
  endtask
  task cfg(input [7:0] a, input [7:0] exp);
  begin
    u_host.cyc(2'h2, a, 32'h0);
    chk({24'h0, cfg_rdata_o}, {24'h0, exp}, "cfg");
  end
  endtask
  task arm;
  begin
    nclk;
    tx_end_i = 1;
    nclk;
    tx_end_i = 0;
  end
  endtask
  task ticks(input integer n);
    repeat (n)
    begin
      nclk;
      bit_tick_i = 1;
      nclk;
      bit_tick_i = 0;
    end
  endtask
  task drop;
  begin
    nclk;
    rx_no_desc_i = 1;
    nclk;
    rx_no_desc_i = 0;
  end
  endtask
  task finish_test;
  begin
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    #100000;
    err_total = err_total + 1;
    finish_test;
  end
  initial
  begin
    repeat (3) nclk;
    rst_n_i = 1;
    rd(5'h12, 32'hFFFF, 32'h0);
    rd(5'h10, 32'hFFFF, 32'h0004);
    cfg(8'h46, 8'h00);
    nclk; eeprom_pwr_i = 8'hA5; eeprom_load_i = 1;
    nclk; eeprom_load_i = 0;
    cfg(8'h47, 8'hA5);
    for (i = 37; i <= 44; i = i + 1)
    begin
      wr(5'h12, i);
      rd(5'h16, 32'hFF, 32'hA5);
    end
    nclk; dword_io_mode_i = 1;
    wr(5'h14, 32'hFFFFFF2C);
    chk({24'h0, pointer_o}, 32'h2C, "pointer");
    rd(5'h14, 32'hFFFF, 32'h2C);
    rd(5'h1C, 32'hFF, 32'hA5);
    nclk; dword_io_mode_i = 0; sw_reset_i = 1;
    nclk; sw_reset_i = 0;
    rd(5'h12, 32'hFFFF, 32'h0);
    $display("done pointer tests");
    repeat (2) drop;
    rd(5'h10, 32'hFFFF, 32'h9004);
    chk({16'h0, drop_cnt_o}, 32'h2, "drop_cnt");
    wr(5'h12, 8'h70);
    rd(5'h10, 32'hFFFF, 32'h2);
    wr(5'h12, 8'h00);
    wr(5'h10, 32'h4040);
    chk({31'h0, irq_output_n_o}, 32'h0, "irq_n");
    rd(5'h10, 32'hFFFF, 32'h9044);
    wr(5'h10, 32'h0040);
    rd(5'h10, 32'hFFFF, 32'h9044);
    wr(5'h10, 32'h1040);
    rd(5'h10, 32'hFFFF, 32'h0044);
    chk({31'h0, irq_output_n_o}, 32'h1, "irq_n");
    wr(5'h12, 8'h03);
    wr(5'h10, 32'h1000);
    rd(5'h10, 32'hFFFF, 32'h1000);
    wr(5'h12, 8'h00);
    drop;
    nclk;
    chk({31'h0, irq_output_n_o}, 32'h1, "irq_n");
    fork
      wr(5'h10, 32'h1040);
      drop;
    join
    rd(5'h10, 32'hFFFF, 32'h9044);
    chk({16'h0, drop_cnt_o}, 32'h4, "drop_cnt");
    wr(5'h12, 8'h03);
    wr(5'h10, 32'h0000);
    wr(5'h12, 8'h00);
    chk({31'h0, irq_output_n_o}, 32'h0, "irq_n");
    wr(5'h10, 32'h1040);
    rd(5'h10, 32'hFFFF, 32'h0044);
    $display("done dropped frame tests");
    nclk;
    half_duplex_i = 1;
    arm;
    ticks(19);
    rd(5'h10, 32'hFFFF, 32'h0044);
    ticks(1);
    rd(5'h10, 32'hFFFF, 32'hA044);
    chk({31'h0, irq_output_n_o}, 32'h1, "irq_n");
    wr(5'h10, 32'h2040);
    rd(5'h10, 32'hFFFF, 32'h0044);
    arm;
    col_i = 1;
    ticks(20);
    col_i = 0;
    rd(5'h10, 32'hFFFF, 32'h0044);
    nclk;
    half_duplex_i = 0;
    arm;
    ticks(20);
    rd(5'h10, 32'hFFFF, 32'h0044);
    nclk;
    half_duplex_i = 1;
    mii_sel_i = 1;
    arm;
    ticks(20);
    rd(5'h10, 32'hFFFF, 32'h0044);
    nclk;
    phy_10bt_hd_i = 1;
    arm;
    ticks(20);
    rd(5'h10, 32'hFFFF, 32'hA044);
    wr(5'h10, 32'h0004);
    rd(5'h10, 32'hFFFF, 32'h0004);
    $display("done collision tests");
    nclk;
    bus_req_i = 1;
    bus_gnt_i = 1;
    repeat (30) nclk;
    bus_req_i = 0;
    bus_gnt_i = 0;
    rd(5'h10, 32'hFFFF, 32'h0004);
    nclk;
    bus_req_i = 1;
    repeat (15) nclk;
    bus_req_i = 0;
    rd(5'h10, 32'hFFFF, 32'h0004);
    nclk;
    bus_req_i = 1;
    repeat (16) nclk;
    bus_req_i = 0;
    rd(5'h10, 32'hFFFF, 32'h8804);
    $display("done grant timeout test");
    finish_test;
  end
endmodule
